/* File: aisc_dev.sv */
// aisc_dev: analog input module control, open-wire test, cyclic and selective conversion
// assumes front-end status pins arrive asynchronously; adc_value_i is converter logic on sys_clk_i
//
// Function
// - pulse test current, compare voltage first
// - over limit sets error bit, value zero
// - open-wire check on 8/16 or 4/8 inputs
// - overflow flag kept per channel
// - disable pin plus no-check stops test pulses
// - pt100 supply switch monitors source line breaks
// - open source jumper sets error, value zero
// - current/voltage mode ignores source line breaks
// - simple variant chain break zeroes all values
// - cyclic mode converts all channels repeatedly
// - conversion 40 ms zero, 60 ms nominal
// - value stored at channel word, high byte first
// - cpu starts selective with one word write
// - selective converts only the addressed channel
// - activity flag high during selective conversion
// - activity flag is module-wide, not per channel
// - cpu reads result after activity falls
// - no output module at selective input address
// - cpu starts selective from periodic task
// - error flag only on faulty channel
`timescale 1ns/1ps
module aisc_dev import aisc_pkg::*; #(
  parameter int TEST_CYC  = TEST_PULSE_CYC,
  parameter int ZERO_CYC  = CONV_ZERO_CYC,
  parameter int NOM_CYC   = CONV_NOM_CYC
) (
  input  wire logic               sys_clk_i,
  input  wire logic               rst_b_i,
  aisc_bus_if.dev                 bus,
  input  wire logic [VAL_W-1:0]   adc_value_i,    // converter result, same clock
  input  wire logic               adc_ovf_i,      // converter over range
  input  wire logic               test_over_i,    // test voltage above limit
  input  wire logic [NCH_MAX-1:0] src_break_i,    // positive source line broken
  input  wire logic [NCH_MAX-1:0] jump_open_i,    // source outputs not jumpered
  input  wire logic               chain_break_i,  // pt100 chain supply broken
  input  wire logic               test_dis_i,     // external test current disable
  input  wire logic               ow_en_i,        // selector I: open-wire signal on
  input  wire logic               ow_all_i,       // check all inputs, else half
  input  wire logic               ch16_i,         // 16-channel operation
  input  wire logic               pt100_sw_i,     // selector I switch 7: pt100 supply
  input  wire logic               cur_volt_i,     // selector II: current/voltage only
  input  wire logic               simple_var_i,   // simpler module variant
  output logic                    test_cur_o,     // test current source on
  output logic      [CH_W-1:0]    ch_sel_o,       // channel multiplexer
  output logic                    conv_run_o,     // converter integrating
  output logic                    act_o           // activity flag
);

  typedef enum logic [1:0] {S_PICK, S_TEST, S_CONV, S_STORE} aisc_dev_e;

  localparam int CONV_STEP = (NOM_CYC - ZERO_CYC) / (1 << VAL_W);

  // status pins, two-stage synchronisers
  localparam int SYN_W = 2 * NCH_MAX + 10;
  logic [SYN_W-1:0]  syn1_r;
  logic [SYN_W-1:0]  syn2_r;
  logic [NCH_MAX-1:0] brk_s;
  logic [NCH_MAX-1:0] jmp_s;
  logic ovf_s, over_s, chain_s, tdis_s, owen_s, owall_s, c16_s, pt_s, cv_s, simp_s;

  aisc_dev_e         st_r;
  logic [31:0]       cnt_r;
  logic [CH_W-1:0]   cyc_ch_r;
  logic              cur_sel_r;
  logic              pend_r;
  logic [CH_W-1:0]   pend_ch_r;
  logic              ow_hit_r;
  logic              ack_r;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] buf_r [NCH_MAX];

  logic              wr_take;
  logic              test_on;
  logic              ow_chk;
  logic [CH_W:0]     nch;
  logic [CH_W:0]     ow_cnt;
  logic [31:0]       conv_lim;
  logic              err;
  logic              zero;
  logic [DATA_W-1:0] word;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    syn1_r <= {src_break_i, jump_open_i, adc_ovf_i, test_over_i, chain_break_i, test_dis_i,
               ow_en_i, ow_all_i, ch16_i, pt100_sw_i, cur_volt_i, simple_var_i};
    syn2_r <= syn1_r;
  end
  assign {brk_s, jmp_s, ovf_s, over_s, chain_s, tdis_s, owen_s, owall_s, c16_s, pt_s, cv_s, simp_s} = syn2_r;

  // ----------------------------------------------------------------
  // channel selection terms
  // ----------------------------------------------------------------
  assign nch      = c16_s ? 5'h10 : 5'h08;
  assign ow_cnt   = c16_s ? (owall_s ? 5'h10 : 5'h08) : (owall_s ? 5'h08 : 5'h04);
  assign ow_chk   = owen_s && ({1'b0, ch_sel_o} < ow_cnt);
  assign test_on  = !(tdis_s && !owen_s);
  assign conv_lim = 32'(ZERO_CYC) + 32'(CONV_STEP) * {20'h00000, adc_value_i};
  assign wr_take  = bus.req && bus.wr && !ack_r;

  // ----------------------------------------------------------------
  // result word of the current channel
  // ----------------------------------------------------------------
  // error only from this channel's own faults
  assign err  = ow_hit_r
              || (pt_s && !cv_s && brk_s[ch_sel_o])
              || (!cv_s && jmp_s[ch_sel_o]);
  assign zero = err || (simp_s && chain_s);
  always_comb begin
    word                        = WORD_RST;
    word[VAL_LSB +: VAL_W]      = zero ? 12'h000 : adc_value_i;
    word[ERR_BIT]               = err;
    word[OVF_BIT]               = ovf_s && !zero;
  end

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      st_r       <= S_PICK;
      cnt_r      <= 32'h0000_0000;
      cyc_ch_r   <= 4'h0;
      ch_sel_o   <= 4'h0;
      cur_sel_r  <= 1'b0;
      ow_hit_r   <= 1'b0;
      test_cur_o <= 1'b0;
      conv_run_o <= 1'b0;
    end else begin
      case (st_r)
        S_PICK: begin
          ch_sel_o   <= pend_r ? pend_ch_r : cyc_ch_r;
          cur_sel_r  <= pend_r;
          cnt_r      <= 32'h0000_0000;
          ow_hit_r   <= 1'b0;
          test_cur_o <= test_on;
          conv_run_o <= !test_on;
          st_r       <= test_on ? S_TEST : S_CONV;
        end
        S_TEST: begin
          cnt_r <= cnt_r + 32'h0000_0001;
          if (cnt_r == 32'(TEST_CYC - 1)) begin
            ow_hit_r   <= ow_chk && over_s;
            test_cur_o <= 1'b0;
            conv_run_o <= 1'b1;
            cnt_r      <= 32'h0000_0000;
            st_r       <= S_CONV;
          end
        end
        S_CONV: begin
          cnt_r <= cnt_r + 32'h0000_0001;
          if (cnt_r >= conv_lim - 32'h0000_0001) begin
            conv_run_o <= 1'b0;
            st_r       <= S_STORE;
          end
        end
        S_STORE: begin
          if (!cur_sel_r) begin
            cyc_ch_r <= ({1'b0, cyc_ch_r} >= nch - 5'h01) ? 4'h0 : cyc_ch_r + 4'h1;
          end
          st_r <= S_PICK;
        end
        default: st_r <= S_PICK;
      endcase
    end
  end

  // circulating buffer, one word per channel
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < NCH_MAX; i++) begin
        buf_r[i] <= WORD_RST;
      end
    end else if (st_r == S_STORE) begin
      buf_r[ch_sel_o] <= word;
    end
  end

  // ----------------------------------------------------------------
  // selective request and activity flag
  // ----------------------------------------------------------------
  // a new write wins over the clear at the end of a conversion
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      pend_r    <= 1'b0;
      pend_ch_r <= 4'h0;
      act_o     <= 1'b0;
    end else begin
      if (wr_take) begin
        pend_r    <= 1'b1;
        pend_ch_r <= bus.addr[ADDR_W-1:1];
        act_o     <= 1'b1;
      end else begin
        if (st_r == S_PICK) begin
          pend_r <= 1'b0;
        end
        if (st_r == S_STORE && cur_sel_r && !pend_r) begin
          act_o <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      ack_r   <= 1'b0;
      rdata_r <= WORD_RST;
    end else begin
      ack_r <= bus.req && !ack_r;
      if (bus.req && !ack_r) begin
        rdata_r          <= buf_r[bus.addr[ADDR_W-1:1]];
        rdata_r[ACT_BIT] <= act_o || wr_take;
      end
    end
  end
  assign bus.ack   = ack_r;
  assign bus.rdata = rdata_r;

endmodule // aisc_dev

/* File: aisc_pkg.sv */
// aisc_pkg: constants shared by the analog input sampling module and its cpu-side controller
// assumes a 200 MHz system clock and a 16-channel word-per-channel buffer on the backplane
package aisc_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ         = 200;
  localparam int TEST_PULSE_US   = 1600;   // open-wire test current pulse, 1.6 ms
  localparam int CONV_ZERO_MS    = 40;     // conversion time at zero input
  localparam int CONV_NOM_MS     = 60;     // conversion time at nominal input
  localparam int SCAN_PERIOD_MS  = 100;    // cpu periodic task interval
  localparam int TEST_PULSE_CYC  = TEST_PULSE_US * CLK_MHZ;
  localparam int CONV_ZERO_CYC   = CONV_ZERO_MS * 1000 * CLK_MHZ;
  localparam int CONV_NOM_CYC    = CONV_NOM_MS * 1000 * CLK_MHZ;
  localparam int SCAN_PERIOD_CYC = SCAN_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int POLL_GAP_CYC    = 64;     // spacing of activity polls in one-shot mode

  // ----------------------------------------------------------------
  // backplane bus and channel word layout
  // ----------------------------------------------------------------
  localparam int NCH_MAX   = 16;
  localparam int CH_W      = 4;
  localparam int ADDR_W    = 5;            // byte address, two bytes per channel
  localparam int DATA_W    = 16;
  localparam int VAL_W     = 12;
  localparam int VAL_LSB   = 4;            // value in bits 15:4
  localparam int ACT_BIT   = 2;            // module-wide activity flag
  localparam int ERR_BIT   = 1;            // open-wire / error flag
  localparam int OVF_BIT   = 0;            // per-channel overflow flag
  localparam logic [DATA_W-1:0] WORD_RST = 16'h0000;

  // ----------------------------------------------------------------
  // controller register map (apb, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;  // [0] periodic enable, [7:4] channel
  localparam logic [7:0] REG_CMD  = 8'h04;  // [0] start selective, [1] read buffer word
  localparam logic [7:0] REG_DATA = 8'h08;  // [15:0] last word, [16] valid
  localparam logic [7:0] REG_STAT = 8'h0C;  // [0] busy, [1] activity last seen
  localparam int CTRL_PER_BIT = 0;
  localparam int CTRL_CH_LSB  = 4;
  localparam int CMD_SEL_BIT  = 0;
  localparam int CMD_RD_BIT   = 1;
  localparam int DATA_VLD_BIT = 16;
  localparam logic [31:0] REG_RST = 32'h0000_0000;

endpackage

/* File: aisc_bus_if.sv */
// aisc_bus_if: backplane i/o bus between the cpu-side controller and the input module
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface aisc_bus_if;
  import aisc_pkg::*;

  logic              req;    // request, held until ack
  logic              wr;     // 1 = word write, 0 = word read
  logic [ADDR_W-1:0] addr;   // byte address, even = channel word
  logic [DATA_W-1:0] wdata;  // write data, ignored by the module
  logic              ack;    // one-cycle answer
  logic [DATA_W-1:0] rdata;  // read word, valid with ack

  modport dev  (input req, wr, addr, wdata, output ack, rdata);
  modport host (output req, wr, addr, wdata, input ack, rdata);
endinterface

/* File: aisc_host.sv */
// aisc_host: cpu-side controller, apb slave registers driving the backplane bus
// assumes an apb master on the system clock and one input module on the bus
`timescale 1ns/1ps
module aisc_host import aisc_pkg::*; #(
  parameter int PERIOD_CYC = SCAN_PERIOD_CYC,
  parameter int POLL_CYC   = POLL_GAP_CYC
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  aisc_bus_if.host         bus
);

  typedef enum logic [1:0] {H_IDLE, H_WR, H_WAIT, H_RD} aisc_hst_e;

  aisc_hst_e         st_r;
  logic [31:0]       ctrl_r;
  logic [DATA_W-1:0] res_r;
  logic              vld_r;
  logic              act_seen_r;
  logic              sel_mode_r;
  logic              req_r;
  logic              wr_r;
  logic [31:0]       per_cnt_r;
  logic              tick_r;
  logic [31:0]       wait_r;
  logic              wr_acc;
  logic              cmd_sel;
  logic              cmd_rd;
  logic [CH_W-1:0]   ch;
  logic              per_en;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  assign wr_acc  = psel_i && penable_i && pready_o && pwrite_i;
  assign cmd_sel = wr_acc && (paddr_i == REG_CMD) && pwdata_i[CMD_SEL_BIT];
  assign cmd_rd  = wr_acc && (paddr_i == REG_CMD) && pwdata_i[CMD_RD_BIT];
  assign ch      = ctrl_r[CTRL_CH_LSB +: CH_W];
  assign per_en  = ctrl_r[CTRL_PER_BIT];

  // answer in the access phase, read data captured in setup
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= REG_RST;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i && !penable_i;
      if (psel_i && !penable_i) begin
        pslverr_o <= !(paddr_i == REG_CTRL || paddr_i == REG_CMD ||
                       paddr_i == REG_DATA || paddr_i == REG_STAT);
        case (paddr_i)
          REG_CTRL: prdata_o <= ctrl_r;
          REG_DATA: prdata_o <= {15'h0000, vld_r, res_r};
          REG_STAT: prdata_o <= {30'h0000_0000, act_seen_r, st_r != H_IDLE};
          default:  prdata_o <= REG_RST;
        endcase
      end
    end
  end

  // control register
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      ctrl_r <= REG_RST;
    end else if (wr_acc && paddr_i == REG_CTRL) begin
      ctrl_r <= pwdata_i;
    end
  end

  // ----------------------------------------------------------------
  // periodic task base
  // ----------------------------------------------------------------
  // tick every period instead of hammering the bus with polls
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i || !per_en) begin
      per_cnt_r <= 32'h0000_0000;
      tick_r    <= 1'b0;
    end else begin
      tick_r    <= per_cnt_r == 32'(PERIOD_CYC - 1);
      per_cnt_r <= (per_cnt_r == 32'(PERIOD_CYC - 1)) ? 32'h0000_0000 : per_cnt_r + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // bus sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      st_r       <= H_IDLE;
      req_r      <= 1'b0;
      wr_r       <= 1'b0;
      sel_mode_r <= 1'b0;
      wait_r     <= 32'h0000_0000;
      res_r      <= WORD_RST;
      vld_r      <= 1'b0;
      act_seen_r <= 1'b0;
    end else begin
      case (st_r)
        H_IDLE: begin
          if (cmd_sel || (per_en && tick_r)) begin
            st_r       <= H_WR;
            req_r      <= 1'b1;
            wr_r       <= 1'b1;
            sel_mode_r <= 1'b1;
            vld_r      <= 1'b0;
          end else if (cmd_rd) begin
            st_r       <= H_RD;
            req_r      <= 1'b1;
            wr_r       <= 1'b0;
            sel_mode_r <= 1'b0;
          end
        end
        H_WR: begin
          if (bus.ack) begin
            req_r  <= 1'b0;
            wait_r <= 32'h0000_0000;
            st_r   <= H_WAIT;
          end
        end
        H_WAIT: begin
          wait_r <= wait_r + 32'h0000_0001;
          if (wait_r >= 32'(per_en ? PERIOD_CYC - 1 : POLL_CYC - 1)) begin
            st_r  <= H_RD;
            req_r <= 1'b1;
            wr_r  <= 1'b0;
          end
        end
        H_RD: begin
          if (bus.ack) begin
            req_r      <= 1'b0;
            act_seen_r <= bus.rdata[ACT_BIT];
            if (sel_mode_r && bus.rdata[ACT_BIT]) begin
              wait_r <= 32'h0000_0000;
              st_r   <= H_WAIT;
            end else begin
              res_r <= bus.rdata;
              vld_r <= 1'b1;
              st_r  <= H_IDLE;
            end
          end
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end

  // only the input module's own channel addresses are used, never an output module's
  assign bus.req   = req_r;
  assign bus.wr    = wr_r;
  assign bus.addr  = {ch, 1'b0};
  assign bus.wdata = WORD_RST;

endmodule // aisc_host

/* File: aisc_bus_properties.sv */
// aisc_bus_properties: timing and word checks on the backplane bus between controller and input module
// assumes one system clock and a synchronous active-low reset shared by both ends
`timescale 1ns/1ps
module aisc_bus_properties import aisc_pkg::*; (
  input  wire logic              sys_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              req_i,
  input  wire logic              wr_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              ack_i,
  input  wire logic [DATA_W-1:0] rdata_i
);
  // ----------------------------------------------------------------
  // bus handshake and word layout
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  req_answered_a: assert property (req_i && !ack_i |=> ack_i)
    else $error("bus request not answered in the next cycle");
  ack_single_a: assert property (ack_i |=> !ack_i)
    else $error("bus answer longer than one cycle");
  ack_caused_a: assert property (ack_i |-> $past(req_i) && !$past(ack_i))
    else $error("bus answer without a pending request");
  req_held_a: assert property (req_i && !ack_i |=> req_i && $stable(addr_i) && $stable(wr_i))
    else $error("bus request changed before its answer");
  req_dropped_a: assert property (ack_i |=> !req_i)
    else $error("bus request kept after its answer");
  err_value_a: assert property (ack_i && rdata_i[ERR_BIT] |-> rdata_i[DATA_W-1:VAL_LSB] == '0)
    else $error("error flag with a nonzero value");
  err_no_ovf_a: assert property (ack_i && rdata_i[ERR_BIT] |-> !rdata_i[OVF_BIT])
    else $error("error flag together with overflow");
  spare_bit_a: assert property (ack_i |-> !rdata_i[3])
    else $error("unused word bit set");
  rdata_hold_a: assert property (!req_i |=> $stable(rdata_i))
    else $error("read word changed without a request");
endmodule // aisc_bus_properties

/* File: aisc_test.sv */
// aisc_test: controller and input module joined over the bus, driven through apb registers
// assumes short conversion parameters so every selective conversion ends within the 20000-step poll loop limit
`timescale 1ns/1ps
module aisc_test import aisc_pkg::*;;
  logic               sys_clk_i, rst_b_i, psel_i, penable_i, pwrite_i;
  logic [7:0]         paddr_i;
  logic [31:0]        pwdata_i, prdata_o, rdv;
  logic               pready_o, pslverr_o, errv;
  logic [VAL_W-1:0]   adc_value_i;
  logic [NCH_MAX-1:0] src_break_i, jump_open_i;
  logic               adc_ovf_i, test_over_i, chain_break_i, test_dis_i, ow_en_i, ow_all_i;
  logic               ch16_i, pt100_sw_i, cur_volt_i, simple_var_i, test_cur_o, act_o, conv_run_o;
  logic [CH_W-1:0]    ch_sel_o;
  int                 error_cnt, checks;

  // ----------------------------------------------------------------
  // structure: both ends, the bus and its checker
  // ----------------------------------------------------------------
  aisc_bus_if bus ();
  aisc_host #(.PERIOD_CYC(200), .POLL_CYC(64)) u_aisc_host (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .bus(bus));
  aisc_dev #(.TEST_CYC(8), .ZERO_CYC(512), .NOM_CYC(4608)) u_aisc_dev (.sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i), .bus(bus), .adc_value_i(adc_value_i), .adc_ovf_i(adc_ovf_i), .test_over_i(test_over_i),
    .src_break_i(src_break_i), .jump_open_i(jump_open_i), .chain_break_i(chain_break_i), .test_dis_i(test_dis_i),
    .ow_en_i(ow_en_i), .ow_all_i(ow_all_i), .ch16_i(ch16_i), .pt100_sw_i(pt100_sw_i), .cur_volt_i(cur_volt_i),
    .simple_var_i(simple_var_i), .test_cur_o(test_cur_o), .ch_sel_o(ch_sel_o), .conv_run_o(conv_run_o),
    .act_o(act_o));
  aisc_bus_properties u_aisc_bus_properties (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .req_i(bus.req),
    .wr_i(bus.wr), .addr_i(bus.addr), .ack_i(bus.ack), .rdata_i(bus.rdata));

  // clock of 5 ns period
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  // ----------------------------------------------------------------
  // tasks: compare, apb transfer, one conversion
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // setup, access held until pready is seen high at an edge, then release and one idle cycle
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] dt);
    int n;
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= dt;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    rdv  = prdata_o;
    errv = pslverr_o;
    if (pready_o !== 1'b1) begin
      error_cnt++;
      final_report();
    end
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  // order one channel (cmd 1) or read its buffer word (cmd 2), watch activity and test pulses until idle, then fetch the result word
  task automatic sel(input logic [3:0] ch, input logic [1:0] cmd, input logic [16:0] exp);
    int   n;
    logic tc, ac, bsy;
    logic [CH_W-1:0] cs;
    repeat (16) @(posedge sys_clk_i);
    xfer(1'b1, REG_CTRL, {24'h0, ch, 4'h0});
    xfer(1'b1, REG_CMD, {30'h0, cmd});
    tc  = 1'b0;
    cs  = ~ch;
    ac  = 1'b0;
    bsy = 1'b1;
    n   = 0;
    while (bsy && n < 20000) begin
      @(negedge sys_clk_i);
      tc |= test_cur_o;
      ac |= act_o;
      if (conv_run_o && act_o) cs = ch_sel_o;
      n++;
      @(posedge sys_clk_i);
      if (n % 32 == 0) begin
        xfer(1'b0, REG_STAT, 32'h0);
        bsy = rdv[0];
      end
    end
    if (bsy) begin
      error_cnt++;
      final_report();
    end
    chk("activity seen", 32'(ac), 32'(cmd == 2'h1));
    if (test_dis_i && !ow_en_i) chk("test pulse", 32'(tc), 32'h0);
    else if (cmd == 2'h1) chk("test pulse on", 32'(tc), 32'h1);
    chk("activity end", 32'(act_o), 32'h0);
    if (cmd == 2'h1) chk("converted channel", 32'(cs), 32'(ch));
    xfer(1'b0, REG_DATA, 32'h0);
    chk("result word", 32'(rdv[16:0]), 32'(exp));
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    error_cnt = 0;
    checks = 0;
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {adc_ovf_i, test_over_i, chain_break_i, test_dis_i, ow_en_i} = '0;
    {pt100_sw_i, cur_volt_i, simple_var_i, src_break_i, jump_open_i} = '0;
    {ow_all_i, ch16_i} = 2'h3;
    adc_value_i = 12'h123;
    rst_b_i = 1'b0;
    repeat (16) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    @(posedge sys_clk_i);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, 8'(i * 4), 32'h0);
      chk("reset register", rdv, REG_RST);
    end
    chk("reset activity", 32'(act_o), 32'h0);
    xfer(1'b0, 8'h10, 32'h0);
    chk("unmapped error", 32'(errv), 32'h1);
    chk("unmapped data", rdv, 32'h0);
    sel(4'h3, 2'h1, 17'h11230);
    sel(4'h3, 2'h2, 17'h11230);
    adc_ovf_i <= 1'b1;
    sel(4'h4, 2'h1, 17'h11231);
    adc_ovf_i <= 1'b0;
    jump_open_i <= 16'h0020;
    sel(4'h5, 2'h1, 17'h10002);
    sel(4'h4, 2'h1, 17'h11230);
    {cur_volt_i, pt100_sw_i, src_break_i} <= {1'b1, 1'b1, 16'h0020};
    sel(4'h5, 2'h1, 17'h11230);
    {cur_volt_i, jump_open_i, pt100_sw_i, src_break_i} <= {1'b0, 16'h0000, 1'b1, 16'h0040};
    sel(4'h6, 2'h1, 17'h10002);
    {pt100_sw_i, src_break_i, ow_en_i, test_over_i} <= {1'b0, 16'h0000, 1'b1, 1'b1};
    sel(4'h2, 2'h1, 17'h10002);
    ow_all_i <= 1'b0;
    sel(4'hA, 2'h1, 17'h11230);
    ch16_i <= 1'b0;
    sel(4'h5, 2'h1, 17'h11230);
    {ow_all_i, ch16_i, ow_en_i, test_over_i, test_dis_i} <= 5'h19;
    sel(4'h1, 2'h1, 17'h11230);
    {test_dis_i, chain_break_i, simple_var_i} <= 3'h3;
    sel(4'h7, 2'h1, 17'h10000);
    // periodic mode: the controller starts and fetches channel 9 on its own
    {chain_break_i, simple_var_i} <= 2'h0;
    xfer(1'b1, REG_CTRL, 32'h0000_0091);
    repeat (256) @(posedge sys_clk_i);
    rdv = 32'h0000_0000;
    for (int k = 0; k < 300 && !rdv[DATA_VLD_BIT]; k++) begin
      repeat (32) @(posedge sys_clk_i);
      xfer(1'b0, REG_DATA, 32'h0);
    end
    chk("periodic word", 32'(rdv[16:0]), 32'h0001_1230);
    final_report();
  end
endmodule // aisc_test
